// ==== rtl/tpsm_port.sv ====
// test point port: strap capture at reset release, then debug outputs
`timescale 1ns/1ps
module tpsm_port
(
    // clock, reset, enable
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         ce,
    // chip reset pin, active low, asynchronous
    input  wire logic                         chipResetLow,
    // probe pins
    input  wire logic [tpsm_pkg::PIN_W-1:0]   debugProbePinsIn,
    output logic      [tpsm_pkg::PIN_W-1:0]   debugProbePinsOut,
    output logic      [tpsm_pkg::PIN_W-1:0]   debugProbePinsOe,
    // fast clock taps forwarded in clock debug
    input  wire logic                         clkTapFast,
    input  wire logic                         clkTapHalf,
    // software output reselection
    input  wire logic                         selLoad,
    input  wire logic [tpsm_pkg::SEL_W-1:0]   selCode,
    input  wire logic [tpsm_pkg::NCO_W-1:0]   varStep,
    // captured mode
    output logic      [tpsm_pkg::MODE_W-1:0]  testMode,
    output logic                              testModeValid
);
    import tpsm_pkg::*;

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    logic [SYNC_W-1:0] syncIn;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic [SYNC_W-1:0] sync3_r;
    logic [SYNC_W-1:0] flt_r;
    logic [SYNC_W-1:0] flt_nxt;

    assign syncIn = {chipResetLow, debugProbePinsIn};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_sync
            // level counts once stages two and three agree
            always_comb
            begin
                flt_nxt[gi] = flt_r[gi];
                if (sync2_r[gi] == sync3_r[gi])
                begin
                    flt_nxt[gi] = sync3_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            flt_r   <= '0;
        end
        else if (ce)
        begin
            sync1_r <= syncIn;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            flt_r   <= flt_nxt;
        end
    end

    logic             rstNFlt;
    logic [PIN_W-1:0] strapFlt;
    logic             relEdge;
    logic             asrtEdge;

    assign rstNFlt  = flt_r[PIN_W];
    // straps taken from the same filter stage as the reset bit
    assign strapFlt = flt_nxt[PIN_W-1:0];
    // release is a rise of the filtered reset level
    assign relEdge  = flt_nxt[PIN_W] && !rstNFlt;
    assign asrtEdge = !flt_nxt[PIN_W];

    // -------------------------------------------------------------------
    // mode capture and output selection
    // -------------------------------------------------------------------
    tpsm_state_t      state_r;
    tpsm_state_t      state_nxt;
    logic [MODE_W-1:0] mode_r;
    logic [MODE_W-1:0] mode_nxt;
    logic [SEL_W-1:0] sel_r;
    logic [SEL_W-1:0] sel_nxt;
    logic             swTouched_r;
    logic             swTouched_nxt;
    logic [NCO_W-1:0] step_r;
    logic [NCO_W-1:0] step_nxt;
    logic [PIN_W-1:0] oe_r;
    logic [PIN_W-1:0] oe_nxt;
    logic [PIN_W-1:0] lvl_r;
    logic [PIN_W-1:0] lvl_nxt;

    function automatic logic [NCO_W-1:0] clampStep(input logic [NCO_W-1:0] s);
        if (s < VAR_STEP_MIN)
            return VAR_STEP_MIN;
        if (s > VAR_STEP_MAX)
            return VAR_STEP_MAX;
        return s;
    endfunction

    always_comb
    begin
        state_nxt     = state_r;
        mode_nxt      = mode_r;
        sel_nxt       = sel_r;
        swTouched_nxt = swTouched_r;
        step_nxt      = step_r;
        case (state_r)
            TPSM_ST_HELD:
            begin
                if (relEdge)
                begin
                    // strap sampled once, pulldowns give zero when open
                    mode_nxt      = strapFlt[MODE_W-1:0];
                    state_nxt     = TPSM_ST_RUN;
                    swTouched_nxt = 1'b0;
                    step_nxt      = VAR_STEP_DEF;
                    if (strapFlt[MODE_W-1:0] == MODE_CLKDBG)
                        sel_nxt = SEL_CLKDBG_MAP;
                    else
                        sel_nxt = SEL_QUIET_MAP;
                end
            end
            TPSM_ST_RUN:
            begin
                if (asrtEdge)
                begin
                    state_nxt = TPSM_ST_HELD;
                    sel_nxt   = SEL_QUIET_MAP;
                end
                else if (selLoad)
                begin
                    sel_nxt       = selCode;
                    step_nxt      = clampStep(varStep);
                    swTouched_nxt = 1'b1;
                end
            end
            default:
            begin
                state_nxt = TPSM_ST_HELD;
                sel_nxt   = SEL_QUIET_MAP;
            end
        endcase
        for (int i = 0; i < PIN_W; i++)
        begin
            oe_nxt[i]  = (state_nxt == TPSM_ST_RUN) && tpsmSelDrives(sel_nxt[2*i +: 2]);
            lvl_nxt[i] = tpsmSelLevel(sel_nxt[2*i +: 2]);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_r     <= TPSM_ST_HELD;
            mode_r      <= MODE_QUIET;
            sel_r       <= SEL_QUIET_MAP;
            swTouched_r <= 1'b0;
            step_r      <= VAR_STEP_DEF;
            oe_r        <= '0;
            lvl_r       <= '0;
        end
        else if (ce)
        begin
            state_r     <= state_nxt;
            mode_r      <= mode_nxt;
            sel_r       <= sel_nxt;
            swTouched_r <= swTouched_nxt;
            step_r      <= step_nxt;
            oe_r        <= oe_nxt;
            lvl_r       <= lvl_nxt;
        end
    end

    // -------------------------------------------------------------------
    // debug clock sources
    // -------------------------------------------------------------------
    logic [NCO_W-1:0]  ncoStep [NCO_CH];
    logic [NCO_CH-1:0] ncoClk;
    logic [PIN_W-1:0]  clkSrc;
    logic              ncoRun;

    assign ncoRun     = state_r == TPSM_ST_RUN;
    assign ncoStep[0] = step_r;
    assign ncoStep[1] = STEP_SLOW;

    generate
        for (gi = 0; gi < NCO_CH; gi++)
        begin : g_nco
            tpsm_nco u_nco
            (
                .clk_sys (clk_sys),
                .rst     (rst),
                .ce      (ce),
                .run     (ncoRun),
                .step    (ncoStep[gi]),
                .clkOut  (ncoClk[gi])
            );
        end
    endgenerate

    always_comb
    begin
        clkSrc           = '0;
        clkSrc[PIN_FAST] = clkTapFast;
        clkSrc[PIN_HALF] = clkTapHalf;
        clkSrc[PIN_VAR]  = ncoClk[0];
        clkSrc[PIN_SLOW] = ncoClk[1];
    end

    // -------------------------------------------------------------------
    // pin drive
    // -------------------------------------------------------------------
    generate
        for (gi = 0; gi < PIN_W; gi++)
        begin : g_pin
            // clock selections forward the source, others the held level
            assign debugProbePinsOut[gi] = (sel_r[2*gi +: 2] == TPSM_SEL_CLK) ?
                                           clkSrc[gi] : lvl_r[gi];
        end
    endgenerate

    assign debugProbePinsOe = oe_r;
    assign testMode         = mode_r;
    assign testModeValid    = state_r == TPSM_ST_RUN;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    a_held_inputs: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == TPSM_ST_HELD) |-> (debugProbePinsOe == '0))
        else $error("probe pins driven while reset held");

    a_reset_hiz: assert property (@(posedge clk_sys)
        rst |=> (debugProbePinsOe == '0) && !testModeValid)
        else $error("probe pins not released by core reset");

    a_release_capture: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && state_r == TPSM_ST_HELD && relEdge)
        |=> (mode_r == $past(strapFlt[MODE_W-1:0])) && testModeValid)
        else $error("strap not captured at release");

    a_no_recapture: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == TPSM_ST_RUN && rstNFlt) ##1 (state_r == TPSM_ST_RUN)
        |-> $stable(mode_r))
        else $error("mode changed without reset cycle");

    a_default_hiz: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == TPSM_ST_RUN && mode_r == MODE_QUIET && !swTouched_r)
        |-> (debugProbePinsOe == '0))
        else $error("quiet mode drives probe pins");

    a_clkdbg_levels: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == TPSM_ST_RUN && mode_r == MODE_CLKDBG && !swTouched_r)
        |-> (debugProbePinsOe == 8'hff) && debugProbePinsOut[3] && !debugProbePinsOut[4]
            && (debugProbePinsOut[6:5] == 2'h3))
        else $error("clock debug levels wrong");

    a_sw_reselect: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && state_r == TPSM_ST_RUN && !asrtEdge && selLoad)
        |=> (sel_r == $past(selCode)) && (debugProbePinsOe[0] == ($past(selCode[1:0]) != 2'h0)))
        else $error("software selection not applied");

    a_dir_change: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && state_r == TPSM_ST_HELD && relEdge && strapFlt[MODE_W-1:0] == MODE_CLKDBG)
        |=> (debugProbePinsOe == 8'hff))
        else $error("pins not turned to outputs after release");

endmodule // tpsm_port

// ==== rtl/tpsm_pkg.sv ====
// constants and types of the test point strap mode port
package tpsm_pkg;

    // -------------------------------------------------------------------
    // widths
    // -------------------------------------------------------------------
    localparam int PIN_W       = 8;
    localparam int MODE_W      = 3;
    localparam int SEL_W       = 2 * PIN_W;
    localparam int SYNC_W      = PIN_W + 1;
    localparam int NCO_W       = 10;
    localparam int NCO_CH      = 2;

    // -------------------------------------------------------------------
    // rates
    // -------------------------------------------------------------------
    localparam int CLK_SYS_HZ  = 100_000_000;
    localparam int NCO_RES_HZ  = 250_000;
    localparam int SLOW_HZ     = 7_500_000;
    localparam int VAR_MIN_HZ  = 700_000;
    localparam int VAR_MAX_HZ  = 22_500_000;
    localparam int VAR_DEF_HZ  = 1_000_000;

    // toggle step per cycle; output rate = step * NCO_RES_HZ / 2
    localparam logic [NCO_W-1:0] NCO_DEN      = NCO_W'(CLK_SYS_HZ / NCO_RES_HZ);
    localparam logic [NCO_W-1:0] STEP_SLOW    = NCO_W'(2 * SLOW_HZ / NCO_RES_HZ);
    localparam logic [NCO_W-1:0] VAR_STEP_MIN =
        NCO_W'((2 * VAR_MIN_HZ + NCO_RES_HZ - 1) / NCO_RES_HZ);
    localparam logic [NCO_W-1:0] VAR_STEP_MAX = NCO_W'(2 * VAR_MAX_HZ / NCO_RES_HZ);
    localparam logic [NCO_W-1:0] VAR_STEP_DEF = NCO_W'(2 * VAR_DEF_HZ / NCO_RES_HZ);

    // -------------------------------------------------------------------
    // modes and selections
    // -------------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_QUIET  = 3'h0;
    localparam logic [MODE_W-1:0] MODE_CLKDBG = 3'h2;

    // debug clock source to pin mapping
    localparam int PIN_VAR  = 2;
    localparam int PIN_SLOW = 7;
    localparam int PIN_FAST = 0;
    localparam int PIN_HALF = 1;

    typedef enum logic [1:0]
    {
        TPSM_SEL_OFF  = 2'h0,
        TPSM_SEL_LOW  = 2'h1,
        TPSM_SEL_HIGH = 2'h2,
        TPSM_SEL_CLK  = 2'h3
    } tpsm_sel_t;

    typedef enum logic
    {
        TPSM_ST_HELD = 1'h0,
        TPSM_ST_RUN  = 1'h1
    } tpsm_state_t;

    // two bits per pin, pin 0 in the low pair
    localparam logic [SEL_W-1:0] SEL_QUIET_MAP  = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_CLKDBG_MAP = 16'he9bf;

    // pin drive enable for one selection
    function automatic logic tpsmSelDrives(input logic [1:0] sel);
        return sel != TPSM_SEL_OFF;
    endfunction

    // static level for one selection
    function automatic logic tpsmSelLevel(input logic [1:0] sel);
        return sel == TPSM_SEL_HIGH;
    endfunction

endpackage

// ==== rtl/tpsm_nco.sv ====
// fractional divider making one debug clock
`timescale 1ns/1ps
module tpsm_nco
(
    // clock and control
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic                      run,
    // toggle step per cycle
    input  wire logic [tpsm_pkg::NCO_W-1:0] step,
    // divided clock
    output logic                           clkOut
);
    import tpsm_pkg::*;

    logic [NCO_W-1:0] acc_r;
    logic [NCO_W-1:0] acc_nxt;
    logic             clk_r;
    logic             clk_nxt;
    logic [NCO_W-1:0] sum;

    always_comb
    begin
        sum     = acc_r + step;
        acc_nxt = sum;
        clk_nxt = clk_r;
        if (!run)
        begin
            acc_nxt = '0;
            clk_nxt = 1'b0;
        end
        else if (sum >= NCO_DEN)
        begin
            acc_nxt = sum - NCO_DEN;
            clk_nxt = ~clk_r;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            acc_r <= '0;
            clk_r <= 1'b0;
        end
        else if (ce)
        begin
            acc_r <= acc_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign clkOut = clk_r;

endmodule // tpsm_nco

// ==== testbench/tpsm_board.sv ====
// board model: strap jumpers on the low pins, pulldowns elsewhere
`timescale 1ns/1ps
module tpsm_board
(
    // jumper straps
    input  wire logic [2:0]                 strapSel,
    // device pad drive
    input  wire logic [tpsm_pkg::PIN_W-1:0] padOut,
    input  wire logic [tpsm_pkg::PIN_W-1:0] padOe,
    // resolved pin levels
    output logic      [tpsm_pkg::PIN_W-1:0] pins
);
    import tpsm_pkg::*;

    // -------------------------------------------------------------------
    // wire resolution
    // -------------------------------------------------------------------
    // undriven low pins follow the jumper, upper pins read low
    always_comb
    begin
        for (int i = 0; i < PIN_W; i++)
        begin
            if (padOe[i])
                pins[i] = padOut[i];
            else if (i < 3)
                pins[i] = strapSel[i];
            else
                pins[i] = 1'b0;
        end
    end
endmodule // tpsm_board

// ==== testbench/tb_top.sv ====
// self-checking bench of the test point strap mode port
`timescale 1ns/1ps
module tb_top;
    import tpsm_pkg::*;

    typedef struct packed
    {
        logic [2:0] strap;
        logic [7:0] oe;
        logic [7:0] lvl;
    } tpsm_row_t;

    logic                clk_sys;
    logic                rst;
    logic                ce;
    logic                chipResetLow;
    logic [PIN_W-1:0]    pinsIn;
    logic [PIN_W-1:0]    pinsOut;
    logic [PIN_W-1:0]    pinsOe;
    logic                clkTapFast;
    logic                clkTapHalf;
    logic                selLoad;
    logic [SEL_W-1:0]    selCode;
    logic [NCO_W-1:0]    varStep;
    logic [MODE_W-1:0]   testMode;
    logic                testModeValid;
    logic [2:0]          strapSel;
    int                  n_fail;
    int                  checked;
    int                  cycles;
    int                  tg2;
    int                  tg7;
    tpsm_row_t           rows [8];

    tpsm_port i_tpsm_port (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .chipResetLow(chipResetLow), .debugProbePinsIn(pinsIn),
        .debugProbePinsOut(pinsOut), .debugProbePinsOe(pinsOe),
        .clkTapFast(clkTapFast), .clkTapHalf(clkTapHalf), .selLoad(selLoad),
        .selCode(selCode), .varStep(varStep), .testMode(testMode),
        .testModeValid(testModeValid));

    tpsm_board i_tpsm_board (.strapSel(strapSel), .padOut(pinsOut),
        .padOe(pinsOe), .pins(pinsIn));

    // -------------------------------------------------------------------
    // clocks and watchdog
    // -------------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys) clkTapFast <= ~clkTapFast;
    always @(posedge clkTapFast) clkTapHalf <= ~clkTapHalf;

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            $display("[FAIL] %0t run timed out", $time);
            end_sim();
        end
    end

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic near(input int got, input int exp, input string what);
        checked++;
        if (got > exp + 1 || got < exp - 1)
        begin
            n_fail++;
            $display("[FAIL] %0t %s toggles %0d exp %0d", $time, what, got, exp);
        end
    endtask

    // count pin2 and pin7 changes over 400 cycles
    task automatic count400();
        logic [PIN_W-1:0] prev;
        tg2 = 0;
        tg7 = 0;
        prev = pinsOut;
        repeat (400)
        begin
            cyc(1);
            tg2 += int'(pinsOut[2] !== prev[2]);
            tg7 += int'(pinsOut[7] !== prev[7]);
            prev = pinsOut;
        end
    endtask

    task automatic release_with(input logic [2:0] s);
        chipResetLow = 1'b0;
        strapSel = s;
        cyc(6);
        chk(16'(pinsOe), 16'h0000, "oe in reset");
        chk(16'(testModeValid), 16'h0000, "valid in reset");
        chipResetLow = 1'b1;
        cyc(6);
    endtask

    task automatic load(input logic [15:0] code, input logic [9:0] step);
        selLoad = 1'b1;
        selCode = code;
        varStep = step;
        cyc(1);
        selLoad = 1'b0;
    endtask

    task automatic end_sim();
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial
    begin
        rows = '{'{3'h0, 8'h00, 8'h00}, '{3'h1, 8'h00, 8'h00}, '{3'h2, 8'hff, 8'h68},
                 '{3'h3, 8'h00, 8'h00}, '{3'h4, 8'h00, 8'h00}, '{3'h5, 8'h00, 8'h00},
                 '{3'h6, 8'h00, 8'h00}, '{3'h7, 8'h00, 8'h00}};
        n_fail = 0;
        checked = 0;
        cycles = 0;
        rst = 1'b1;
        ce = 1'b1;
        chipResetLow = 1'b0;
        strapSel = 3'h0;
        clkTapFast = 1'b0;
        clkTapHalf = 1'b0;
        selLoad = 1'b0;
        selCode = 16'h0000;
        varStep = 10'h008;
        cyc(8);
        rst = 1'b0;
        foreach (rows[i])
        begin
            release_with(rows[i].strap);
            chk(16'(testMode), 16'(rows[i].strap), "mode");
            chk(16'(testModeValid), 16'h0001, "valid");
            chk(16'(pinsOe), 16'(rows[i].oe), "oe");
            chk(16'(pinsOut & pinsOe & 8'h78), 16'(rows[i].lvl), "levels");
        end
        strapSel = 3'h2;
        cyc(10);
        chk(16'(testMode), 16'h0007, "strap change in run");
        chk(16'(pinsOe), 16'h0000, "oe after strap change");
        release_with(3'h2);
        #1;
        chk(16'({pinsOut[1:0]}), 16'({clkTapHalf, clkTapFast}), "tap forward");
        count400();
        near(tg7, 60, "slow clock");
        near(tg2, 8, "var clock default");
        load(16'h86e4, 10'h008);
        cyc(1);
        chk(16'(pinsOe), 16'h00be, "sw oe");
        chk(16'(pinsOut & pinsOe), 16'h0094, "sw levels");
        selLoad = 1'b1;
        selCode = 16'hffff;
        cyc(1);
        load(16'h0030, 10'h000);
        cyc(1);
        chk(16'(pinsOe), 16'h0004, "back to back");
        count400();
        near(tg2, 6, "var clamp low");
        load(16'h0030, 10'h028);
        count400();
        near(tg2, 40, "var step");
        // clock enable low freezes selection and dividers
        ce = 1'b0;
        load(16'h0000, 10'h008);
        count400();
        chk(16'(tg2 + tg7), 16'h0000, "frozen clocks");
        chk(16'(pinsOe), 16'h0004, "frozen select");
        ce = 1'b1;
        // core reset in mid run, chip reset pin already high
        rst = 1'b1;
        cyc(2);
        chk(16'(pinsOe), 16'h0000, "oe in core reset");
        chk(16'(testModeValid), 16'h0000, "valid in core reset");
        rst = 1'b0;
        cyc(6);
        chk(16'(testMode), 16'h0002, "capture after core reset");
        chk(16'(pinsOe), 16'h00ff, "oe after core reset");
        chipResetLow = 1'b0;
        cyc(6);
        chk(16'(pinsOe), 16'h0000, "oe on re-reset");
        chk(16'(testMode), 16'h0002, "mode kept");
        load(16'hffff, 10'h008);
        cyc(2);
        chk(16'(pinsOe), 16'h0000, "load in reset");
        end_sim();
    end
endmodule // tb_top
